// *** logic/sshlp_defs.svh ***
`ifndef SSHLP_DEFS_SVH
`define SSHLP_DEFS_SVH

// ============================================================
// Register byte addresses
`define SSHLP_DATA_LINE_IO_ADDR 12'h000
`define SSHLP_CLOCK_LINE_IO_ADDR 12'h004
`define SSHLP_CONTROL_ADDR 12'h008
`define SSHLP_FALL_COND_ADDR 12'h00C
`define SSHLP_RISE_COND_ADDR 12'h010
`define SSHLP_SAMPLED_ADDR 12'h014
`define SSHLP_NEW_SAMPLE_ADDR 12'h018

// ============================================================
// Field positions of the control register
`define SSHLP_CTL_ENABLE_BIT 0
`define SSHLP_CTL_STRETCH_BIT 1
`define SSHLP_CTL_COND_STRETCH_BIT 2
`define SSHLP_CTL_ACTIVE_BIT 3

// ============================================================
// Reset values
`define SSHLP_LINE_DRIVE_RST 1'b1
`define SSHLP_FLAG_RST 1'b0

`endif

// *** logic/sshlp_pkg.sv ***
package sshlp_pkg;

	// Synchronised pin levels and their edges, one cycle per event.
	typedef struct packed {
		logic clk_lvl;
		logic dat_lvl;
		logic clk_rise;
		logic clk_fall;
		logic dat_rise;
		logic dat_fall;
	} sshlp_lines_t;

	// Control register contents written by software.
	typedef struct packed {
		logic cond_stretch_enable;
		logic stretch_enable;
		logic block_enable;
	} sshlp_ctrl_t;

endpackage

// *** logic/sshlp_sync_serial_helper.sv ***
`timescale 1ns/1ps
`include "sshlp_defs.svh"

module sshlp_sync_serial_helper
	import sshlp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic port_b_clk_out,
	input wire logic port_b_clk_oe,
	input wire logic port_b_dat_out,
	input wire logic port_b_dat_oe,
	input wire logic serial_clock_line_in,
	input wire logic serial_data_line_in,
	output logic serial_clock_line_out,
	output logic serial_clock_line_oe,
	output logic serial_data_line_out,
	output logic serial_data_line_oe,
	output logic falling_data_irq,
	output logic rising_data_irq
);

	// ============================================================
	// APB decode
	logic access;
	logic wr_en;
	logic rd_en;
	logic hit_dat;
	logic hit_clk;
	logic hit_ctl;
	logic hit_fall;
	logic hit_rise;
	logic hit_samp;
	logic hit_new;
	logic mapped;

	assign access = psel & penable & pready;
	assign wr_en = access & pwrite;
	assign rd_en = access & ~pwrite;
	assign hit_dat = paddr == `SSHLP_DATA_LINE_IO_ADDR;
	assign hit_clk = paddr == `SSHLP_CLOCK_LINE_IO_ADDR;
	assign hit_ctl = paddr == `SSHLP_CONTROL_ADDR;
	assign hit_fall = paddr == `SSHLP_FALL_COND_ADDR;
	assign hit_rise = paddr == `SSHLP_RISE_COND_ADDR;
	assign hit_samp = paddr == `SSHLP_SAMPLED_ADDR;
	assign hit_new = paddr == `SSHLP_NEW_SAMPLE_ADDR;
	assign mapped = hit_dat | hit_clk | hit_ctl | hit_fall | hit_rise | hit_samp | hit_new;

	// Write and read strobes, one per register that reacts to the bus.
	logic wr_ctl;
	logic wr_dat;
	logic wr_clk;
	logic wr_fall;
	logic wr_rise;
	logic rd_samp;
	assign wr_ctl = wr_en & hit_ctl;
	assign wr_dat = wr_en & hit_dat;
	assign wr_clk = wr_en & hit_clk;
	assign wr_fall = wr_en & hit_fall;
	assign wr_rise = wr_en & hit_rise;
	assign rd_samp = rd_en & hit_samp;

	// ============================================================
	// Pin synchronisers
	// Three stages; an edge counts once stages two and three disagree with the last accepted level.
	logic [2:0] clk_sync_r;
	logic [2:0] dat_sync_r;
	logic clk_lvl_r;
	logic dat_lvl_r;
	sshlp_lines_t ln;

	logic clk_agree;
	logic dat_agree;
	assign clk_agree = clk_sync_r[1] == clk_sync_r[2];
	assign dat_agree = dat_sync_r[1] == dat_sync_r[2];

	logic [2:0] clk_sync_nxt;
	logic [2:0] dat_sync_nxt;
	logic clk_lvl_nxt;
	logic dat_lvl_nxt;
	assign clk_sync_nxt = {clk_sync_r[1:0], serial_clock_line_in};
	assign dat_sync_nxt = {dat_sync_r[1:0], serial_data_line_in};
	assign clk_lvl_nxt = clk_agree ? clk_sync_r[2] : clk_lvl_r;
	assign dat_lvl_nxt = dat_agree ? dat_sync_r[2] : dat_lvl_r;

	// Both lines idle high, so the chains reset to one and no false edge follows reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_sync_r <= 3'h7;
			clk_lvl_r <= 1'b1;
		end else begin
			clk_sync_r <= clk_sync_nxt;
			clk_lvl_r <= clk_lvl_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dat_sync_r <= 3'h7;
			dat_lvl_r <= 1'b1;
		end else begin
			dat_sync_r <= dat_sync_nxt;
			dat_lvl_r <= dat_lvl_nxt;
		end
	end
	assign ln.clk_lvl = clk_lvl_r;
	assign ln.dat_lvl = dat_lvl_r;
	assign ln.clk_rise = clk_agree & clk_sync_r[2] & ~clk_lvl_r;
	assign ln.clk_fall = clk_agree & ~clk_sync_r[2] & clk_lvl_r;
	assign ln.dat_rise = dat_agree & dat_sync_r[2] & ~dat_lvl_r;
	assign ln.dat_fall = dat_agree & ~dat_sync_r[2] & dat_lvl_r;

	// ============================================================
	// Registers
	sshlp_ctrl_t ctrl_r;
	logic dat_drive_r;
	logic clk_drive_r;
	logic fall_flag_r;
	logic rise_flag_r;
	logic active_r;
	logic sampled_r;
	logic new_r;

	// Detections use the clock level seen in the same cycle the data edge is accepted.
	logic fall_det;
	logic rise_det;
	logic stretch_go;
	logic release_wr;
	assign fall_det = ctrl_r.block_enable & ln.dat_fall & ln.clk_lvl;
	assign rise_det = ctrl_r.block_enable & ln.dat_rise & ln.clk_lvl;
	assign release_wr = wr_en & hit_samp;
	assign stretch_go = ctrl_r.block_enable & ln.clk_fall
		& (ctrl_r.stretch_enable | (ctrl_r.cond_stretch_enable & fall_flag_r));

	// Next values; hardware sets win over a software clear in the same cycle.
	sshlp_ctrl_t ctrl_nxt;
	logic dat_drive_nxt;
	logic clk_drive_nxt;
	logic fall_flag_nxt;
	logic rise_flag_nxt;
	logic active_nxt;
	logic sampled_nxt;
	logic new_nxt;
	assign ctrl_nxt.block_enable = wr_ctl ? pwdata[`SSHLP_CTL_ENABLE_BIT] : ctrl_r.block_enable;
	assign ctrl_nxt.stretch_enable = wr_ctl ? pwdata[`SSHLP_CTL_STRETCH_BIT] : ctrl_r.stretch_enable;
	assign ctrl_nxt.cond_stretch_enable = wr_ctl ? pwdata[`SSHLP_CTL_COND_STRETCH_BIT] : ctrl_r.cond_stretch_enable;
	assign dat_drive_nxt = wr_dat ? pwdata[0] : dat_drive_r;
	assign clk_drive_nxt = wr_clk ? pwdata[0] : clk_drive_r;
	assign fall_flag_nxt = fall_det | (fall_flag_r & ~wr_fall);
	assign rise_flag_nxt = rise_det | (rise_flag_r & ~wr_rise);
	// A stretching clock fall (stretch_go) in the very cycle of a release write starts a new hold at once.
	assign active_nxt = stretch_go | (active_r & ~release_wr);
	assign sampled_nxt = ln.clk_rise ? ln.dat_lvl : sampled_r;
	assign new_nxt = ln.clk_rise | (new_r & ~rd_samp);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dat_drive_r <= `SSHLP_LINE_DRIVE_RST;
		end else begin
			dat_drive_r <= dat_drive_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_drive_r <= `SSHLP_LINE_DRIVE_RST;
		end else begin
			clk_drive_r <= clk_drive_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fall_flag_r <= `SSHLP_FLAG_RST;
		end else begin
			fall_flag_r <= fall_flag_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rise_flag_r <= `SSHLP_FLAG_RST;
		end else begin
			rise_flag_r <= rise_flag_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_r <= `SSHLP_FLAG_RST;
		end else begin
			active_r <= active_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sampled_r <= `SSHLP_FLAG_RST;
		end else begin
			sampled_r <= sampled_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			new_r <= `SSHLP_FLAG_RST;
		end else begin
			new_r <= new_nxt;
		end
	end

	// ============================================================
	// Pin drive
	// Open drain: the pin is pulled low when driving a zero, and the clock pin also while a hold is active; otherwise it is released.
	logic clk_low;
	logic dat_low;
	assign clk_low = ctrl_r.block_enable ? (~clk_drive_r | active_r) : 1'b0;
	assign dat_low = ctrl_r.block_enable ? ~dat_drive_r : 1'b0;

	// Disabled: port B keeps its own setting of both pins, one cycle late.
	logic clk_out_nxt;
	logic clk_oe_nxt;
	logic dat_out_nxt;
	logic dat_oe_nxt;
	assign clk_out_nxt = ctrl_r.block_enable ? 1'b0 : port_b_clk_out;
	assign clk_oe_nxt = ctrl_r.block_enable ? clk_low : port_b_clk_oe;
	assign dat_out_nxt = ctrl_r.block_enable ? 1'b0 : port_b_dat_out;
	assign dat_oe_nxt = ctrl_r.block_enable ? dat_low : port_b_dat_oe;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_clock_line_out <= 1'b0;
		end else begin
			serial_clock_line_out <= clk_out_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_clock_line_oe <= 1'b0;
		end else begin
			serial_clock_line_oe <= clk_oe_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_data_line_out <= 1'b0;
		end else begin
			serial_data_line_out <= dat_out_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_data_line_oe <= 1'b0;
		end else begin
			serial_data_line_oe <= dat_oe_nxt;
		end
	end

	// ============================================================
	// Interrupt pulses and read data
	logic [7:0] rd_byte;
	logic [7:0] rd_dat_byte;
	logic [7:0] rd_clk_byte;
	logic [7:0] rd_ctl_byte;
	logic [7:0] rd_fall_byte;
	logic [7:0] rd_rise_byte;
	logic [7:0] rd_samp_byte;
	logic [7:0] rd_new_byte;
	assign rd_dat_byte = {7'h00, ln.dat_lvl};
	assign rd_clk_byte = {7'h00, ln.clk_lvl};
	assign rd_ctl_byte = {4'h0, active_r, ctrl_r};
	assign rd_fall_byte = {7'h00, fall_flag_r};
	assign rd_rise_byte = {7'h00, rise_flag_r};
	assign rd_samp_byte = {7'h00, sampled_r};
	assign rd_new_byte = {7'h00, new_r};
	assign rd_byte = hit_dat ? rd_dat_byte :
		hit_clk ? rd_clk_byte :
		hit_ctl ? rd_ctl_byte :
		hit_fall ? rd_fall_byte :
		hit_rise ? rd_rise_byte :
		hit_samp ? rd_samp_byte :
		hit_new ? rd_new_byte : 8'h00;

	logic pready_nxt;
	logic pslverr_nxt;
	logic [31:0] prdata_nxt;
	// One wait state on every access, so a master must always wait for ready.
	assign pready_nxt = psel & penable & ~pready;
	assign pslverr_nxt = psel & penable & ~pready & ~mapped;
	assign prdata_nxt = (psel & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			falling_data_irq <= 1'b0;
		end else begin
			falling_data_irq <= fall_det;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rising_data_irq <= 1'b0;
		end else begin
			rising_data_irq <= rise_det;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else begin
			prdata <= prdata_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= pready_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= pslverr_nxt;
		end
	end

endmodule

// *** test/sshlp_assertions.sv ***
`timescale 1ns/1ps
// ==========
// Port checks; control bits are rebuilt here from the APB writes.
module sshlp_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic serial_clock_line_in,
	input wire logic serial_data_line_in,
	input wire logic serial_clock_line_oe,
	input wire logic serial_data_line_oe,
	input wire logic falling_data_irq,
	input wire logic rising_data_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic en_r, st_r, cd_r;
	wire wr = psel && penable && pready && pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{en_r, st_r, cd_r} <= 3'h1;
		end else begin
			if (wr && paddr == 12'h008) {st_r, en_r} <= pwdata[1:0];
			if (wr && paddr == 12'h004) cd_r <= pwdata[0];
		end
	end
	AST_DATA_LOW: assert property (
		wr && paddr == 12'h000 && en_r && !pwdata[0] |-> ##2 serial_data_line_oe) else $error("data not driven");
	AST_DATA_REL: assert property (
		wr && paddr == 12'h000 && en_r && pwdata[0] |-> ##2 !serial_data_line_oe) else $error("data not freed");
	AST_CLOCK_LOW: assert property (
		wr && paddr == 12'h004 && en_r && !pwdata[0] |-> ##2 serial_clock_line_oe) else $error("clock not driven");
	AST_FALL_IRQ: assert property (
		falling_data_irq |-> $past(serial_clock_line_in, 2) && !$past(serial_data_line_in, 2) ##1 !falling_data_irq)
		else $error("bad fall irq");
	AST_RISE_IRQ: assert property (
		rising_data_irq |-> $past(serial_clock_line_in, 2) && $past(serial_data_line_in, 2) ##1 !rising_data_irq)
		else $error("bad rise irq");
	AST_OFF_QUIET: assert property (
		!en_r |-> !falling_data_irq && !rising_data_irq) else $error("irq while off");
	AST_STRETCH: assert property (
		en_r && st_r && $fell(serial_clock_line_in) |-> ##[2:8] serial_clock_line_oe) else $error("no stretch");
	AST_RELEASE: assert property (
		wr && paddr == 12'h014 && en_r && cd_r |-> ##[1:3] !serial_clock_line_oe) else $error("no release");
	cover property (falling_data_irq);
	cover property (rising_data_irq);
	cover property (serial_clock_line_oe && st_r);
endmodule
bind sshlp_sync_serial_helper sshlp_assertions chk (.*);

// *** test/sshlp_peer.sv ***
`timescale 1ns/1ps
// ==========
// Far side: released lines float high on pull-ups; its clock runs only in send_bit.
module sshlp_peer (
	input wire logic clk_oe,
	input wire logic clk_out,
	input wire logic dat_oe,
	input wire logic dat_out,
	output logic clk_line,
	output logic dat_line
);
	logic clk_low = 1'h0;
	logic dat_low = 1'h0;
	assign clk_line = !(clk_low || (clk_oe && !clk_out));
	assign dat_line = !(dat_low || (dat_oe && !dat_out));
	task automatic send_bit(input logic b);
		#3 clk_low = 1'h1;
		#20 dat_low = !b;
		#20 clk_low = 1'h0;
		#40;
	endtask
	task automatic cond(input logic b);
		#103 dat_low = !b;
		#100;
	endtask
endmodule

// *** test/sshlp_sync_serial_helper_bench.sv ***
`timescale 1ns/1ps
// ==========
// Scenarios; the peer changes lines off the pclk grid, as a real far side would.
module sshlp_sync_serial_helper_bench;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, port_b_dat_oe = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, serial_clock_line_out, serial_clock_line_oe, serial_data_line_out, serial_data_line_oe;
	logic serial_clock_line_in, serial_data_line_in, falling_data_irq, rising_data_irq, err;
	logic port_b_clk_out = 1'h0, port_b_clk_oe = 1'h0, port_b_dat_out = 1'h0;
	int failures = 0, check_count = 0, cyc = 0, fall_irqs = 0, rise_irqs = 0;
	always @(posedge pclk) begin
		if (falling_data_irq === 1'h1) fall_irqs <= fall_irqs + 1;
		if (rising_data_irq === 1'h1) rise_irqs <= rise_irqs + 1;
	end
	sshlp_sync_serial_helper dut (.*);
	sshlp_peer peer (.clk_oe(serial_clock_line_oe), .clk_out(serial_clock_line_out), .dat_oe(serial_data_line_oe),
		.dat_out(serial_data_line_out), .clk_line(serial_clock_line_in), .dat_line(serial_data_line_in));
	initial forever #5 pclk = !pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("failures=%0d check_count=%0d", failures, check_count);
		if (failures == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic io(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		io(1'h1, a, d);
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		io(1'h0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic t_reset();
		rc(12'h000, 32'h1);
		rc(12'h004, 32'h1);
		rc(12'h008, 32'h0);
		rc(12'h00C, 32'h0);
		rc(12'h010, 32'h0);
		wr(12'h018, 32'h1);
		rc(12'h018, 32'h0);
		rc(12'h014, 32'h0);
		rc(12'h01C, 32'h0);
		chk(err, 32'h1);
	endtask
	task automatic t_off();
		port_b_dat_oe <= 1'h1;
		port_b_clk_out <= 1'h1;
		port_b_clk_oe <= 1'h1;
		repeat (8) @(posedge pclk);
		rc(12'h000, 32'h0);
		chk(serial_data_line_oe, 32'h1);
		chk(serial_clock_line_out, 32'h1);
		chk(serial_clock_line_oe, 32'h1);
		port_b_dat_out <= 1'h1;
		repeat (8) @(posedge pclk);
		rc(12'h000, 32'h1);
		chk(serial_data_line_out, 32'h1);
		port_b_dat_oe <= 1'h0;
		port_b_dat_out <= 1'h0;
		port_b_clk_out <= 1'h0;
		port_b_clk_oe <= 1'h0;
		repeat (8) @(posedge pclk);
		rc(12'h00C, 32'h0);
		rc(12'h010, 32'h0);
	endtask
	task automatic t_lines();
		wr(12'h008, 32'h1);
		wr(12'h000, 32'h0);
		repeat (8) @(posedge pclk);
		rc(12'h000, 32'h0);
		chk(serial_data_line_oe, 32'h1);
		chk(serial_data_line_out, 32'h0);
		rc(12'h00C, 32'h1);
		wr(12'h00C, 32'h0);
		rc(12'h00C, 32'h0);
		wr(12'h000, 32'h1);
		repeat (8) @(posedge pclk);
		rc(12'h010, 32'h1);
		wr(12'h010, 32'h5);
		rc(12'h010, 32'h0);
		wr(12'h004, 32'h0);
		wr(12'h004, 32'h1);
		peer.cond(1'h0);
		rc(12'h000, 32'h0);
		rc(12'h00C, 32'h1);
		peer.cond(1'h1);
	endtask
	task automatic t_sample();
		peer.send_bit(1'h1);
		peer.send_bit(1'h0);
		rc(12'h018, 32'h1);
		rc(12'h014, 32'h0);
		rc(12'h018, 32'h0);
		peer.send_bit(1'h1);
		rc(12'h014, 32'h1);
	endtask
	task automatic t_stretch();
		wr(12'h008, 32'h3);
		peer.send_bit(1'h1);
		#200;
		rc(12'h008, 32'hB);
		wr(12'h014, 32'h0);
		#100;
		chk(serial_clock_line_in, 32'h1);
		rc(12'h008, 32'h3);
		wr(12'h00C, 32'h0);
		wr(12'h008, 32'h5);
		peer.send_bit(1'h1);
		#200;
		chk(serial_clock_line_in, 32'h1);
		peer.cond(1'h0);
		peer.send_bit(1'h0);
		#200;
		chk(serial_clock_line_in, 32'h0);
		rc(12'h008, 32'hD);
		wr(12'h014, 32'h0);
		chk(fall_irqs, 32'h3);
		chk(rise_irqs, 32'h2);
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		t_reset();
		t_off();
		t_lines();
		t_sample();
		t_stretch();
		wrap_up();
	end
endmodule
